/* pkg/acs_pkg.sv */
// Purpose: shared constants of the channel-select serial converter control block
// Assumes: 8-bit control word and 8-bit results, 16 serial clocks per conversion
// Notes:   every field position and phase count of the serial frame lives here
package acs_pkg;
    localparam int          ACS_DATA_W      = 8;     // result and control word width
    localparam int          ACS_CHAN_W      = 3;     // channel field width
    localparam int          ACS_CNT_W       = 4;     // serial edge counter width
    localparam int          ACS_FIFO_DEPTH  = 4;     // result buffer depth
    localparam int          ACS_SYNC_STAGES = 2;     // flops in each synchroniser
    // control word layout
    localparam int          ACS_CHAN_MSB    = 5;     // chan_sel_msb position
    localparam int          ACS_CHAN_LSB    = 3;     // chan_sel_lsb position
    localparam logic [2:0]  ACS_CHAN_RESET  = 3'h0;  // channel after power-up
    // serial phases, as rising edges completed within a conversion
    localparam logic [3:0]  ACS_CTRL_LAST   = 4'h7;  // eighth rising edge closes the word
    localparam logic [3:0]  ACS_TRACK_LAST  = 4'h2;  // track ends before falling edge 4
    localparam logic [3:0]  ACS_HOLD_START  = 4'h3;  // falling edge 4 starts hold
    localparam logic [3:0]  ACS_DATA_FIRST  = 4'h4;  // falling edge 5 sends the msb
    localparam logic [3:0]  ACS_DATA_LAST   = 4'hb;  // falling edge 12 sends the lsb
    localparam logic [3:0]  ACS_CONV_LAST   = 4'hf;  // sixteenth edge of a conversion
    localparam logic [3:0]  ACS_CNT_ZERO    = 4'h0;
    localparam logic [7:0]  ACS_RESULT_ZERO = 8'h00;
endpackage

/* hdl/acs_fifo.sv */
// Purpose: small synchronous FIFO between the converter core and the serial link
// Assumes: one clock, synchronous active-high reset
// Notes:   read data come from the storage registers at the read pointer
`timescale 1ns/1ps
module acs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0]   count_q;
    wire              push;
    wire              pop;

    // full and empty come straight from the occupancy count
    assign wr_ready_out = (count_q != (PTR_W+1)'(DEPTH));
    assign rd_valid_out = (count_q != '0);
    assign rd_data_out  = mem_q[rd_ptr_q];
    assign push         = wr_valid_in & wr_ready_out;
    assign pop          = rd_ready_in & rd_valid_out;

    // storage, written only on an accepted push
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= wr_data_in;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end
endmodule

/* hdl/acs_ctrl.sv */
// Purpose: serial frame control of an eight-channel 8-bit converter
// Assumes: serial clock is its own domain and stops outside frames; core clock runs free
// Notes:   converter codes enter on the core side through a 4-word buffer
`timescale 1ns/1ps
module acs_ctrl
    import acs_pkg::*;
#(
    parameter int DEPTH = acs_pkg::ACS_FIFO_DEPTH
) (
    input  wire logic                            core_clk_in,
    input  wire logic                            rst_in,
    // serial link, clocked by the host
    input  wire logic                            sclk_in,
    input  wire logic                            frame_sel_n_in,
    input  wire logic                            sdata_in,
    output logic                                 sdata_out,
    output logic                                 sdata_oe_out,
    // converter core side
    input  wire logic [acs_pkg::ACS_DATA_W-1:0]  code_data_in,
    input  wire logic                            code_valid_in,
    output logic                                 code_ready_out,
    output logic      [acs_pkg::ACS_CHAN_W-1:0]  chan_sel_out,
    output logic                                 track_out,
    output logic                                 power_up_out
);
    import acs_pkg::*;

    // ---------------- core domain ----------------
    logic                  link_rst_q;
    logic [ACS_DATA_W-1:0] hold_word_q;
    logic                  hold_full_q;
    logic [ACS_DATA_W-1:0] fifo_data;
    logic                  fifo_valid;
    logic [ACS_SYNC_STAGES-1:0] take_sync_q;
    logic [ACS_SYNC_STAGES-1:0] chan_sync_q;
    logic [ACS_SYNC_STAGES-1:0] track_sync_q;
    logic [ACS_SYNC_STAGES-1:0] sel_sync_q;
    logic [ACS_SYNC_STAGES-1:0] apd_sync_q;
    logic                  take_seen_q;
    logic                  chan_seen_q;
    logic [ACS_CHAN_W-1:0] chan_sel_q;
    logic                  track_q;
    logic                  power_up_q;
    wire                   take_evt;
    wire                   chan_evt;
    wire                   fifo_pop;

    // ---------------- link domain ----------------
    logic [ACS_CNT_W-1:0]  rise_cnt_q;     // rising edges completed, mod 16
    logic [ACS_DATA_W-2:0] shift_q;
    logic [ACS_CHAN_W-1:0] next_chan_q;
    logic [ACS_CHAN_W-1:0] conv_chan_q;
    logic                  chan_tgl_q;
    logic [ACS_DATA_W-1:0] result_q;
    logic                  take_tgl_q;
    logic                  sdata_q;
    logic                  link_track_q;
    logic                  auto_pd_q;
    wire  [ACS_DATA_W-1:0] ctrl_word;
    wire                   ctrl_done;
    wire                   conv_wrap;
    wire                   in_data;
    wire  [ACS_CNT_W-1:0]  bit_sel;
    wire                   frame_idle;

    // result buffer; its ready is the converter core's back-pressure
    acs_fifo #(
        .WIDTH (ACS_DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_in       (core_clk_in),
        .rst_in       (rst_in),
        .wr_data_in   (code_data_in),
        .wr_valid_in  (code_valid_in),
        .wr_ready_out (code_ready_out),
        .rd_data_out  (fifo_data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (fifo_pop)
    );

    // edge detection reads only the second synchroniser stage
    assign take_evt = take_sync_q[1] ^ take_seen_q;
    assign chan_evt = chan_sync_q[1] ^ chan_seen_q;
    // refill the hold word when empty or when the link has just taken it
    assign fifo_pop = fifo_valid & (~hold_full_q | take_evt);

    // link logic reset, held as a register so the link side sees a clean level
    always_ff @(posedge core_clk_in) begin
        link_rst_q <= rst_in;
    end

    // synchronisers for every single-bit signal the link hands over
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            take_sync_q  <= '0;
            chan_sync_q  <= '0;
            track_sync_q <= '0;
            sel_sync_q   <= '1;
            apd_sync_q   <= '0;
        end else begin
            take_sync_q  <= {take_sync_q[0], take_tgl_q};
            chan_sync_q  <= {chan_sync_q[0], chan_tgl_q};
            track_sync_q <= {track_sync_q[0], link_track_q};
            sel_sync_q   <= {sel_sync_q[0], frame_sel_n_in};
            apd_sync_q   <= {apd_sync_q[0], auto_pd_q};
        end
    end

    // hold word: while full, stable until the link signals it took it, so a plain multi-bit read of a full word is safe
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            hold_word_q <= ACS_RESULT_ZERO;
            hold_full_q <= 1'b0;
            take_seen_q <= 1'b0;
        end else begin
            take_seen_q <= take_sync_q[1];
            if (fifo_pop) begin
                hold_word_q <= fifo_data;
                hold_full_q <= 1'b1;
            end else if (take_evt) begin
                hold_full_q <= 1'b0;         // link reuses the old word if none is ready
            end
        end
    end

    // channel for the analog mux, taken when the link announces a new conversion
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            chan_seen_q <= 1'b0;
            chan_sel_q  <= ACS_CHAN_RESET;
        end else begin
            chan_seen_q <= chan_sync_q[1];
            if (chan_evt) begin
                chan_sel_q <= conv_chan_q;
            end
        end
    end

    // power and track levels toward the analog core
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            track_q    <= 1'b0;
            power_up_q <= 1'b0;
        end else begin
            track_q    <= track_sync_q[1] & ~sel_sync_q[1];
            power_up_q <= ~sel_sync_q[1] & ~apd_sync_q[1];
        end
    end

    assign chan_sel_out = chan_sel_q;
    assign track_out    = track_q;
    assign power_up_out = power_up_q;

    // ---------------- link side timing ----------------
    // all link logic counts rising serial edges; rise_cnt_q holds how many have
    // completed in the current conversion, modulo 16, so every phase below is
    // named by the count that an edge, rising or falling, sees when it arrives
    //
    // falling edge k of a conversion sees rise_cnt_q == k-1:
    //   edges 1 to 3   count 0 to 2    track phase, output line low
    //   edge 4         count 3         hold starts, result word captured
    //   edges 5 to 12  count 4 to 11   result bits 7 down to 0 on the line
    //   edges 13 to 16 count 12 to 15  trailing zeros
    //   edge 16        count 15        automatic power-down begins
    //
    // rising edge k of a conversion sees rise_cnt_q == k-1:
    //   edges 1 to 8   count 0 to 7    control word shifts in, msb first
    //   edge 8         count 7         channel field latched as next channel
    //   edge 16        count 15        next channel becomes conversion channel
    //
    // frame select high clears the counter, the shifter and the output flops
    // asynchronously, so a frame cut short leaves nothing half done behind it;
    // the channel registers are kept, since the latched code must survive gaps
    //
    // the three ways a frame can open:
    //   select falls, clock high:  first clock fall is falling edge 1
    //   select falls, clock low:   the select fall stands in for falling edge 1
    //   both fall together:        either order of evaluation gives edge 1
    // in every case the count is zero when the first rising edge arrives, so
    // the data bits land on the same edges; only the track level differs, and
    // it is made to start at the select fall by its reset level
    //
    // crossing into the core clock:
    //   take_tgl_q   toggles at falling edge 4, asks the core for a new word
    //   chan_tgl_q   toggles at rising edge 16, conv_chan_q is then stable
    //                for a whole conversion, far longer than the synchroniser
    //   link_track_q level, passes two flops before the core reads it
    //   auto_pd_q    level, passes two flops before the core reads it
    // toggles rather than pulses, because the serial clock may be faster than
    // the core clock and a one-period pulse would slip between core edges
    //
    // crossing into the link:
    //   hold_word_q  multi-bit, read at falling edge 4 only; the core changes
    //                it only after the take toggle, or while it is empty, so a
    //                user must keep a word waiting before a frame opens
    //   link_rst_q   one core flop, released while the serial clock is still
    //
    // limitation: the automatic power-down lasts one serial period between
    // conversions, shorter than a core period, so power_up_out may not show it

    // ---------------- link side decode ----------------
    assign frame_idle = frame_sel_n_in;
    assign ctrl_word  = {shift_q, sdata_in};
    assign ctrl_done  = (rise_cnt_q == ACS_CTRL_LAST);
    assign conv_wrap  = (rise_cnt_q == ACS_CONV_LAST);
    assign in_data    = (rise_cnt_q >= ACS_DATA_FIRST) && (rise_cnt_q <= ACS_DATA_LAST);
    assign bit_sel    = ACS_DATA_LAST - rise_cnt_q;

    // edge counter; frame select high clears it, so the clock is ignored outside frames
    // and the order of the two falling edges does not matter
    always_ff @(posedge sclk_in or posedge frame_idle) begin
        if (frame_idle) begin
            rise_cnt_q <= ACS_CNT_ZERO;
        end else begin
            rise_cnt_q <= rise_cnt_q + 1'b1;
        end
    end

    // control word shifter; only the first eight rising edges load it
    always_ff @(posedge sclk_in or posedge frame_idle) begin
        if (frame_idle) begin
            shift_q <= '0;
        end else if (rise_cnt_q <= ACS_CTRL_LAST) begin
            shift_q <= ctrl_word[ACS_DATA_W-2:0];
        end
    end

    // channel registers survive frame gaps; only the core reset clears them
    always_ff @(posedge sclk_in or posedge link_rst_q) begin
        if (link_rst_q) begin
            next_chan_q <= ACS_CHAN_RESET;
            conv_chan_q <= ACS_CHAN_RESET;
            chan_tgl_q  <= 1'b0;
        end else begin
            if (ctrl_done && !frame_idle) begin
                next_chan_q <= ctrl_word[ACS_CHAN_MSB:ACS_CHAN_LSB];
            end
            if (conv_wrap && !frame_idle) begin
                conv_chan_q <= next_chan_q;
                chan_tgl_q  <= ~chan_tgl_q;
            end
        end
    end

    // result capture at the start of hold; the toggle tells the core to refill
    always_ff @(negedge sclk_in or posedge link_rst_q) begin
        if (link_rst_q) begin
            result_q   <= ACS_RESULT_ZERO;
            take_tgl_q <= 1'b0;
        end else if (!frame_idle && rise_cnt_q == ACS_HOLD_START) begin
            result_q   <= hold_word_q;
            take_tgl_q <= ~take_tgl_q;
        end
    end

    // serial output, track phase and automatic power-down, all on falling edges
    always_ff @(negedge sclk_in or posedge frame_idle) begin
        if (frame_idle) begin
            sdata_q      <= 1'b0;
            link_track_q <= 1'b1;            // track opens with the frame; core masks it while idle
            auto_pd_q    <= 1'b0;
        end else begin
            sdata_q      <= in_data ? result_q[bit_sel[2:0]] : 1'b0;
            link_track_q <= (rise_cnt_q <= ACS_TRACK_LAST);
            if (conv_wrap) begin
                auto_pd_q <= 1'b1;
            end else if (rise_cnt_q == ACS_CNT_ZERO) begin
                auto_pd_q <= 1'b0;
            end
        end
    end

    assign sdata_out    = sdata_q;
    // enable follows frame select directly; a flop here would miss the first bit period
    assign sdata_oe_out = ~frame_sel_n_in;
endmodule

/* verification/acs_ctrl_chk.sv */
// Purpose: port checks of the serial converter control block
// Assumes: link counters clear while frame select is high
// Notes:   serial-side checks keep their own rising-edge count
`timescale 1ns/1ps
module acs_ctrl_chk
    import acs_pkg::*;
#(
    parameter int DEPTH = 4
) (
    input  wire logic                           core_clk_in,
    input  wire logic                           rst_in,
    input  wire logic                           sclk_in,
    input  wire logic                           frame_sel_n_in,
    input  wire logic                           sdata_out,
    input  wire logic                           sdata_oe_out,
    input  wire logic [acs_pkg::ACS_CHAN_W-1:0] chan_sel_out,
    input  wire logic                           track_out,
    input  wire logic                           power_up_out
);
    logic [3:0] rise_cnt_q;
    // count clears between frames, so an aborted frame cannot skew it
    always_ff @(posedge sclk_in or posedge frame_sel_n_in) begin
        if (frame_sel_n_in) rise_cnt_q <= 4'h0;
        else rise_cnt_q <= rise_cnt_q + 4'h1;
    end
    // six idle samples cover the 2-3 cycle synchroniser delay
    sequence s_idle;
        frame_sel_n_in [*6];
    endsequence
    sequence s_start;
        $fell(frame_sel_n_in);
    endsequence
    chk_oe_follows_frame: assert property (@(posedge core_clk_in) disable iff (rst_in)
        sdata_oe_out == !frame_sel_n_in) else $error("output enable differs from frame select");
    chk_oe_at_sclk: assert property (@(negedge sclk_in) disable iff (rst_in)
        !frame_sel_n_in |-> sdata_oe_out) else $error("data line released inside frame");
    chk_dout_idle_low: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_idle |-> !sdata_out) else $error("data output high while idle");
    chk_pad_zeros: assert property (@(posedge sclk_in) disable iff (rst_in || frame_sel_n_in)
        (rise_cnt_q < 4'h4 || rise_cnt_q > 4'hb) |-> !sdata_out) else $error("padding bit not zero");
    chk_power_idle_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_idle |-> !power_up_out) else $error("powered while idle");
    chk_power_frame_on: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_start |-> ##[1:5] power_up_out) else $error("no power-up in frame");
    chk_track_idle: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_idle |-> !track_out) else $error("tracking while idle");
    chk_chan_after_reset: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $fell(rst_in) |-> chan_sel_out == ACS_CHAN_RESET) else $error("channel not zero after reset");
    chk_chan_idle_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_idle |-> $stable(chan_sel_out)) else $error("channel moved while idle");
endmodule
bind acs_ctrl acs_ctrl_chk #(.DEPTH(DEPTH)) u_chk (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .sclk_in        (sclk_in),
    .frame_sel_n_in (frame_sel_n_in),
    .sdata_out      (sdata_out),
    .sdata_oe_out   (sdata_oe_out),
    .chan_sel_out   (chan_sel_out),
    .track_out      (track_out),
    .power_up_out   (power_up_out)
);

/* verification/acs_host_model.sv */
// Purpose: serial host that frames conversions for the control block
// Assumes: 32 ns serial period; clock stands still between frames
// Notes:   gathers all 16 output bits of a conversion into one word
`timescale 1ns/1ps
module acs_host_model (
    output logic        sclk_out,
    output logic        frame_sel_n_out,
    output logic        sdata_out,
    input  wire logic   sdata_in,
    output logic [15:0] word_out,
    output logic        word_stb_out
);
    initial begin
        sclk_out = 1'b1;
        frame_sel_n_out = 1'b1;
        sdata_out = 1'b0;
        word_out = 16'h0000;
        word_stb_out = 1'b0;
    end
    // mode 0: select falls with clock high, 1: clock low first, 2: both together
    task automatic frame(input int mode, input int n, input logic [31:0] ctrl);
        logic [15:0] w = 16'h0000;
        sclk_out = (mode != 1);
        #20;
        if (mode == 0) frame_sel_n_out = 1'b0;
        #16;
        // whole conversions only, n of them back to back
        for (int i = 0; i < 16 * n; i++) begin
            sclk_out = 1'b0;
            frame_sel_n_out = 1'b0;
            sdata_out = ctrl[8 * (i / 16) + 7 - i % 8];
            #16 sclk_out = 1'b1;
            w = {w[14:0], sdata_in};
            word_out = w;
            word_stb_out = (i % 16 == 15);
            #16 word_stb_out = 1'b0;
        end
        frame_sel_n_out = 1'b1;
        #20;
    endtask
endmodule

/* verification/acs_ctrl_tb_top.sv */
// Purpose: self-checking bench of the channel-select serial control block
// Assumes: host model frames conversions; bench pushes converter codes
// Notes:   expected serial words are queued when their codes are pushed
`timescale 1ns/1ps
module acs_ctrl_tb_top;
    import acs_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  code = 8'h00;
    logic        code_vld = 1'b0;
    logic        sclk, fsel_n, din, dout, dout_oe, rdy, trk, pwr, stb;
    logic        sd_hold = 1'b0;
    logic [2:0]  chan, cur_ch = 3'h0;
    logic [15:0] word, last_w;
    logic [15:0] exp_q[$];
    logic [31:0] seed = 32'h07ee;
    int          error_cnt = 0;
    int          total_checks = 0;
    wire         line = dout_oe ? dout : ~sd_hold;
    always #50 core_clk = ~core_clk;
    // a released line must not keep looking driven
    always @(dout) if (dout_oe) sd_hold = dout;
    acs_ctrl u_dut (.core_clk_in(core_clk), .rst_in(rst), .sclk_in(sclk), .frame_sel_n_in(fsel_n),
        .sdata_in(din), .sdata_out(dout), .sdata_oe_out(dout_oe), .code_data_in(code),
        .code_valid_in(code_vld), .code_ready_out(rdy), .chan_sel_out(chan), .track_out(trk),
        .power_up_out(pwr));
    acs_host_model u_host (.sclk_out(sclk), .frame_sel_n_out(fsel_n), .sdata_out(din),
        .sdata_in(line), .word_out(word), .word_stb_out(stb));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // random ignored bits around the channel field
    function automatic logic [7:0] mk(input logic [2:0] ch);
        seed = lfsr(seed);
        return {seed[7:6], ch, seed[2:0]};
    endfunction
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp_sig(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD word exp %h got %h", e, g);
        end
    endtask
    // push a random code; valid stays up so pushes run back to back
    task automatic pushr();
        int k = 0;
        seed = lfsr(seed);
        @(negedge core_clk);
        code = seed[15:8];
        code_vld = 1'b1;
        while (rdy !== 1'b1 && k < 40) begin
            @(negedge core_clk);
            k++;
        end
        if (k == 40) begin
            error_cnt++;
            end_sim();
        end
        @(posedge core_clk);
        last_w = {4'h0, seed[15:8], 4'h0};
        exp_q.push_back(last_w);
    endtask
    task automatic gap(input int n);
        @(negedge core_clk);
        code_vld = 1'b0;
        repeat (n) @(negedge core_clk);
    endtask
    // one frame; the channel must not have moved 300 ns into the frame, inside the first conversion, then takes the last word's field
    task automatic run(input int mode, input int n, input logic [31:0] ctrl);
        fork
            u_host.frame(mode, n, ctrl);
            #300 cmp_sig("chan_mid", {5'h00, cur_ch}, {5'h00, chan});
        join
        gap(6);
        cur_ch = ctrl[8 * (n - 1) + 3 +: 3];
        cmp_sig("chan", {5'h00, cur_ch}, {5'h00, chan});
    endtask
    always @(posedge stb) begin
        if (exp_q.size() == 0) cmp_word(16'hxxxx, word);
        else cmp_word(exp_q.pop_front(), word);
    end
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        cmp_sig("chan_reset", 8'h00, {5'h00, chan});
        // every channel, select orders cycling
        for (int i = 0; i < 8; i++) begin
            pushr();
            gap(2);
            run(i % 3, 1, {24'h0, mk(3'(7 - i))});
        end
        // continuous conversions in one frame
        repeat (3) pushr();
        gap(2);
        run(0, 3, {8'h00, mk(3'h6), mk(3'h1), mk(3'h3)});
        // fill buffer and hold word, refuse one, then drain
        repeat (5) pushr();
        gap(2);
        cmp_sig("ready_full", 8'h00, {7'h00, rdy});
        code = 8'ha5;
        code_vld = 1'b1;
        repeat (3) @(negedge core_clk);
        code_vld = 1'b0;
        repeat (5) run(1, 1, {24'h0, mk(3'h2)});
        cmp_sig("ready_empty", 8'h01, {7'h00, rdy});
        // empty buffer: the last code is sent again
        exp_q.push_back(last_w);
        run(2, 1, {24'h0, mk(3'h5)});
        cmp_sig("pending", 8'h00, 8'(exp_q.size()));
        end_sim();
    end
endmodule
